// File: cpu_core_model.sv
/*
 * Core-side partner: takes offered vectors and ends handlers on command.
 * Assumes the clock of irq_ctrl; the bench calls its tasks.
 */
module cpu_core_model (
    // Clock
    input  wire        clk,
    // Offer
    input  wire        irq_pending,
    input  wire [15:0] irq_vector,
    input  wire [3:0]  irq_source,
    // Answer
    output logic       take_ack,
    output logic       handler_return
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        take_ack = 1'b0;
        handler_return = 1'b0;
    end
    // Bounded wait, so a missing offer reports got low
    task automatic take(output logic got, output logic [15:0] vec, output logic [3:0] src);
        got = 1'b0;
        for (int n = 0; n < 20 && !got; n++) begin
            @(negedge clk);
            got = (irq_pending === 1'b1);
        end
        vec = irq_vector;
        src = irq_source;
        if (got) begin
            @(posedge clk) take_ack <= 1'b1;
            @(posedge clk) take_ack <= 1'b0;
        end
    endtask
    task automatic ret();
        @(posedge clk) handler_return <= 1'b1;
        @(posedge clk) handler_return <= 1'b0;
    endtask
endmodule // cpu_core_model

// File: irq_arbiter.v
/*
 * Combinational arbiter: picks the highest-level eligible request,
 * ties broken by lowest index (fixed polling order).
 * Assumes requests, enables and levels are stable within the cycle.
 */
`include "irq_ctrl_regs.vh"

module irq_arbiter #(
    parameter N = `NUM_SOURCES
) (
    // Requests and configuration
    input  wire [N-1:0]   req,
    input  wire [N-1:0]   enable,
    input  wire [2*N-1:0] level,
    // Preemption threshold: only levels above it compete
    input  wire           thr_valid,
    input  wire [1:0]     thr_level,
    // Result
    output reg            win_valid,
    output reg  [3:0]     win_index,
    output reg  [1:0]     win_level
);

    integer i;
    reg [1:0] lv;

    always @* begin
        win_valid = 1'b0;
        win_index = 4'h0;
        win_level = 2'b00;
        lv        = 2'b00;
        // Scan from last to first so the lowest index wins a tie
        for (i = N - 1; i >= 0; i = i - 1) begin
            lv = level[2*i +: 2];
            if (req[i] && enable[i] && (!thr_valid || lv > thr_level) &&
                (!win_valid || lv >= win_level)) begin
                win_valid = 1'b1;
                win_index = i[3:0];
                win_level = lv;
            end
        end
    end

endmodule // irq_arbiter

// File: irq_ctrl.v
/*
 * Four-level, ten-source interrupt controller with APB register access,
 * nesting stack of levels in service and a vector output to the core.
 * Assumes the core takes a vector on take_ack and reports each handler
 * return by writing the return register or pulsing handler_return.
 */
// The APB interface to the registers was decided locally.
`include "irq_ctrl_regs.vh"

module irq_ctrl #(
    parameter N = `NUM_SOURCES
) (
    // Clock and reset
    input  wire         clk,
    input  wire         nrst,
    // APB slave
    input  wire         psel,
    input  wire         penable,
    input  wire         pwrite,
    input  wire [11:0]  paddr,
    input  wire [31:0]  pwdata,
    input  wire [3:0]   pstrb,
    output wire         pready,
    output reg  [31:0]  prdata,
    output wire         pslverr,
    // Request sources, level high, held until cleared by the source
    input  wire         external_request_pin_0,
    input  wire         external_request_pin_1,
    input  wire         timer0_req,
    input  wire         timer1_req,
    input  wire         timer2_req,
    input  wire         serial_req,
    input  wire         spi_req,
    input  wire         two_wire_req,
    input  wire         keypad_req,
    input  wire         counter_array_req,
    // Core side
    output wire         irq_pending,
    output reg  [15:0]  irq_vector,
    output reg  [3:0]   irq_source,
    input  wire         take_ack,
    input  wire         handler_return,
    output reg  [3:0]   nest_depth
);

    // Configuration registers
    reg [7:0] irq_enable_first_r;
    reg [6:0] irq_priority_low_first_r;
    reg [6:0] irq_priority_high_first_r;
    reg [2:0] irq_enable_second_r;
    reg [2:0] irq_priority_low_second_r;
    reg [2:0] irq_priority_high_second_r;

    // Nesting: one bit per level in service
    reg [3:0] in_service_r;

    wire         global_irq_enable = irq_enable_first_r[`BIT_GLOBAL_ENABLE];
    wire         counter_array_irq_enable = irq_enable_first_r[6];
    wire         timer2_irq_enable = irq_enable_first_r[5];
    wire         serial_irq_enable = irq_enable_first_r[4];
    wire         timer1_irq_enable = irq_enable_first_r[3];
    wire         ext_pin1_irq_enable = irq_enable_first_r[2];
    wire         timer0_irq_enable = irq_enable_first_r[1];
    wire         ext_pin0_irq_enable = irq_enable_first_r[0];
    wire         spi_irq_enable = irq_enable_second_r[2];
    wire         two_wire_irq_enable = irq_enable_second_r[1];
    wire         keypad_irq_enable = irq_enable_second_r[0];

    // Per-source priority bits; the level is high bit over low bit
    wire         ext_pin0_prio_low = irq_priority_low_first_r[0];
    wire         timer0_prio_low = irq_priority_low_first_r[1];
    wire         ext_pin1_prio_low = irq_priority_low_first_r[2];
    wire         timer1_prio_low = irq_priority_low_first_r[3];
    wire         serial_prio_low = irq_priority_low_first_r[4];
    wire         timer2_prio_low = irq_priority_low_first_r[5];
    wire         counter_array_prio_low = irq_priority_low_first_r[6];
    wire         keypad_prio_low = irq_priority_low_second_r[0];
    wire         two_wire_prio_low = irq_priority_low_second_r[1];
    wire         spi_prio_low = irq_priority_low_second_r[2];
    wire         ext_pin0_prio_high = irq_priority_high_first_r[0];
    wire         timer0_prio_high = irq_priority_high_first_r[1];
    wire         ext_pin1_prio_high = irq_priority_high_first_r[2];
    wire         timer1_prio_high = irq_priority_high_first_r[3];
    wire         serial_prio_high = irq_priority_high_first_r[4];
    wire         timer2_prio_high = irq_priority_high_first_r[5];
    wire         counter_array_prio_high = irq_priority_high_first_r[6];
    wire         keypad_prio_high = irq_priority_high_second_r[0];
    wire         two_wire_prio_high = irq_priority_high_second_r[1];
    wire         spi_prio_high = irq_priority_high_second_r[2];

    // Requests arranged in polling order
    wire [N-1:0] req_vec = {two_wire_req, spi_req, keypad_req,
                            counter_array_req, timer2_req, serial_req,
                            timer1_req, external_request_pin_1, timer0_req,
                            external_request_pin_0};
    wire [N-1:0] en_vec = {two_wire_irq_enable, spi_irq_enable,
                           keypad_irq_enable, counter_array_irq_enable,
                           timer2_irq_enable, serial_irq_enable,
                           timer1_irq_enable, ext_pin1_irq_enable,
                           timer0_irq_enable, ext_pin0_irq_enable};
    wire [N-1:0] en_gated = global_irq_enable ? en_vec : {N{1'b0}};
    wire [N-1:0] prio_high = {two_wire_prio_high, spi_prio_high, keypad_prio_high,
                              counter_array_prio_high, timer2_prio_high, serial_prio_high,
                              timer1_prio_high, ext_pin1_prio_high, timer0_prio_high,
                              ext_pin0_prio_high};
    wire [N-1:0] prio_low = {two_wire_prio_low, spi_prio_low, keypad_prio_low,
                             counter_array_prio_low, timer2_prio_low, serial_prio_low,
                             timer1_prio_low, ext_pin1_prio_low, timer0_prio_low,
                             ext_pin0_prio_low};

    // Two bits per source: high bit over low bit
    wire [2*N-1:0] level_vec;
    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : g_level
            assign level_vec[2*g +: 2] = {prio_high[g], prio_low[g]};
        end
    endgenerate

    // Current service level is the highest bit set
    reg       thr_valid;
    reg [1:0] thr_level;
    always @* begin
        thr_valid = |in_service_r;
        if (in_service_r[3])
            thr_level = 2'd3;
        else if (in_service_r[2])
            thr_level = 2'd2;
        else if (in_service_r[1])
            thr_level = 2'd1;
        else
            thr_level = 2'd0;
    end

    wire       win_valid;
    wire [3:0] win_index;
    wire [1:0] win_level;

    irq_arbiter #(
        .N(N)
    ) u_arb (
        .req       (req_vec),
        .enable    (en_gated),
        .level     (level_vec),
        .thr_valid (thr_valid),
        .thr_level (thr_level),
        .win_valid (win_valid),
        .win_index (win_index),
        .win_level (win_level)
    );

    // Vector lookup
    reg [15:0] vec_nxt;
    always @* begin
        case (win_index)
            `SRC_EXT0:    vec_nxt = `VEC_EXT0;
            `SRC_TIMER0:  vec_nxt = `VEC_TIMER0;
            `SRC_EXT1:    vec_nxt = `VEC_EXT1;
            `SRC_TIMER1:  vec_nxt = `VEC_TIMER1;
            `SRC_SERIAL:  vec_nxt = `VEC_SERIAL;
            `SRC_TIMER2:  vec_nxt = `VEC_TIMER2;
            `SRC_COUNTER: vec_nxt = `VEC_COUNTER;
            `SRC_KEYPAD:  vec_nxt = `VEC_KEYPAD;
            `SRC_SPI:     vec_nxt = `VEC_SPI;
            `SRC_TWOWIRE: vec_nxt = `VEC_TWOWIRE;
            default:      vec_nxt = 16'h0000;
        endcase
    end

    // Vector registered; pending valid only while the registered pick holds
    reg        pend_r;
    reg [1:0]  pend_level_r;
    assign irq_pending = pend_r && win_valid && (win_index == irq_source);

    // APB: zero wait states, every access completes in its access phase
    wire apb_wr = psel && penable && pwrite;
    wire apb_rd = psel && penable && !pwrite;
    // Word index of the access; only aligned words are mapped
    wire [9:0] reg_idx = paddr[11:2];
    wire       word_ok = (paddr[1:0] == 2'b00);
    wire       sel_enable_first = word_ok && (reg_idx == `OFS_ENABLE_FIRST);
    wire       sel_enable_second = word_ok && (reg_idx == `OFS_ENABLE_SECOND);
    wire       sel_prio_low_second = word_ok && (reg_idx == `OFS_PRIO_LOW_SECOND);
    wire       sel_prio_high_second = word_ok && (reg_idx == `OFS_PRIO_HIGH_SECOND);
    wire       sel_prio_high_first = word_ok && (reg_idx == `OFS_PRIO_HIGH_FIRST);
    wire       sel_prio_low_first = word_ok && (reg_idx == `OFS_PRIO_LOW_FIRST);
    wire       sel_status = word_ok && (reg_idx == `OFS_STATUS);
    wire       sel_return = word_ok && (reg_idx == `OFS_RETURN);
    wire ret_wr = apb_wr && sel_return && pstrb[0];
    wire do_return = handler_return || ret_wr;
    wire do_take = take_ack && irq_pending;
    wire mapped = sel_enable_first || sel_enable_second || sel_prio_low_second ||
                  sel_prio_high_second || sel_prio_high_first || sel_prio_low_first ||
                  sel_status || sel_return;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // Byte lane 0 carries all writable register data; the status word also uses lane 1
    wire wr_lane0 = apb_wr && pstrb[0];
    wire we_enable_first = wr_lane0 && sel_enable_first;
    wire we_prio_low_first = wr_lane0 && sel_prio_low_first;
    wire we_prio_high_first = wr_lane0 && sel_prio_high_first;
    wire we_enable_second = wr_lane0 && sel_enable_second;
    wire we_prio_low_second = wr_lane0 && sel_prio_low_second;
    wire we_prio_high_second = wr_lane0 && sel_prio_high_second;

    always @(posedge clk) begin
        if (!nrst) begin
            irq_enable_first_r <= `RST_ENABLE_FIRST;
        end else if (we_enable_first) begin
            irq_enable_first_r <= pwdata[7:0];
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            irq_priority_low_first_r <= `RST_FIRST_BANK;
        end else if (we_prio_low_first) begin
            irq_priority_low_first_r <= pwdata[6:0];
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            irq_priority_high_first_r <= `RST_FIRST_BANK;
        end else if (we_prio_high_first) begin
            irq_priority_high_first_r <= pwdata[6:0];
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            irq_enable_second_r <= `RST_SECOND_BANK;
        end else if (we_enable_second) begin
            irq_enable_second_r <= pwdata[2:0];
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            irq_priority_low_second_r <= `RST_SECOND_BANK;
        end else if (we_prio_low_second) begin
            irq_priority_low_second_r <= pwdata[2:0];
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            irq_priority_high_second_r <= `RST_SECOND_BANK;
        end else if (we_prio_high_second) begin
            irq_priority_high_second_r <= pwdata[2:0];
        end
    end

    // Status: pending flag, levels in service, depth, offered source
    wire [31:0] status_word = {16'h0000, irq_pending, 3'b000, in_service_r, nest_depth,
                               irq_source};

    // Read mux, registered at the access edge is not needed: data is combinational
    always @* begin
        prdata = 32'h0000_0000;
        if (apb_rd && word_ok) begin
            case (reg_idx)
                `OFS_ENABLE_FIRST:     prdata = {24'h00_0000, irq_enable_first_r};
                `OFS_PRIO_LOW_FIRST:   prdata = {25'h000_0000, irq_priority_low_first_r};
                `OFS_PRIO_HIGH_FIRST:  prdata = {25'h000_0000, irq_priority_high_first_r};
                `OFS_ENABLE_SECOND:    prdata = {29'h0000_0000, irq_enable_second_r};
                `OFS_PRIO_LOW_SECOND:  prdata = {29'h0000_0000, irq_priority_low_second_r};
                `OFS_PRIO_HIGH_SECOND: prdata = {29'h0000_0000, irq_priority_high_second_r};
                `OFS_STATUS:           prdata = status_word;
                default:               prdata = 32'h0000_0000;
            endcase
        end
    end

    // Highest level in service, cleared on return
    reg [3:0] top_bit;
    always @* begin
        if (in_service_r[3])
            top_bit = 4'b1000;
        else if (in_service_r[2])
            top_bit = 4'b0100;
        else if (in_service_r[1])
            top_bit = 4'b0010;
        else
            top_bit = in_service_r & 4'b0001;
    end

    reg [3:0] in_service_nxt;
    always @* begin
        in_service_nxt = in_service_r;
        if (do_return)
            in_service_nxt = in_service_nxt & ~top_bit;
        // A take in the same cycle as a return still lands
        if (do_take)
            in_service_nxt = in_service_nxt | (4'b0001 << pend_level_r);
    end

    always @(posedge clk) begin
        if (!nrst) begin
            in_service_r <= 4'b0000;
            nest_depth   <= 4'h0;
        end else begin
            in_service_r <= in_service_nxt;
            nest_depth   <= {3'b000, in_service_nxt[0]} + {3'b000, in_service_nxt[1]} +
                            {3'b000, in_service_nxt[2]} + {3'b000, in_service_nxt[3]};
        end
    end

    // Offer registers: the vector trails the winner by one cycle
    always @(posedge clk) begin
        if (!nrst) begin
            pend_r       <= 1'b0;
            pend_level_r <= 2'b00;
            irq_vector   <= 16'h0000;
            irq_source   <= 4'h0;
        end else begin
            // Drop the offer in the take cycle so one winner is never taken twice
            pend_r       <= win_valid && !do_take;
            pend_level_r <= win_level;
            irq_vector   <= vec_nxt;
            irq_source   <= win_index;
        end
    end

endmodule // irq_ctrl

// File: irq_ctrl_properties.sv
/*
 * Checker for irq_ctrl: bus answer timing, vector map and nesting depth.
 * Assumes it is bound to irq_ctrl and sees only that module's ports.
 */
`include "irq_ctrl_regs.vh"

module irq_ctrl_checker #(
    parameter N = `NUM_SOURCES
) (
    // Clock and reset
    input wire        clk,
    input wire        nrst,
    // Bus
    input wire        psel,
    input wire        penable,
    input wire        pready,
    input wire [31:0] prdata,
    input wire        pslverr,
    // Sources
    input wire        external_request_pin_0,
    input wire        external_request_pin_1,
    input wire        timer0_req,
    input wire        timer1_req,
    input wire        timer2_req,
    input wire        serial_req,
    input wire        spi_req,
    input wire        two_wire_req,
    input wire        keypad_req,
    input wire        counter_array_req,
    // Core side
    input wire        irq_pending,
    input wire [15:0] irq_vector,
    input wire [3:0]  irq_source,
    input wire        take_ack,
    input wire        handler_return,
    input wire [3:0]  nest_depth
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    wire [9:0] reqs = {two_wire_req, spi_req, keypad_req, counter_array_req, timer2_req,
                       serial_req, timer1_req, external_request_pin_1, timer0_req,
                       external_request_pin_0};
    // Classic slots sit eight apart; the last two share one vector
    function automatic [15:0] vec_of(input [3:0] s);
        vec_of = (s > 4'h7) ? 16'h0043 : {10'h000, s[2:0], 3'h3};
    endfunction
    sequence take_s;
        take_ack && irq_pending;
    endsequence
    sequence ret_s;
        handler_return && !take_ack && nest_depth != 4'h0;
    endsequence
    ready_always_a: assert property (pready) else $error("pready low");
    slverr_access_a: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access");
    rdata_idle_a: assert property (!(psel && penable) |-> prdata == 32'h0000_0000)
        else $error("prdata outside access");
    vector_map_a: assert property (irq_pending |-> irq_vector == vec_of(irq_source))
        else $error("vector does not match source");
    offer_live_a: assert property (irq_pending |-> reqs[irq_source])
        else $error("offered source not requesting");
    take_gap_a: assert property (take_s |=> !irq_pending)
        else $error("offer kept after take");
    take_depth_a: assert property (take_s ##0 !handler_return |=>
        nest_depth == $past(nest_depth) + 4'h1) else $error("depth not raised");
    ret_depth_a: assert property (ret_s |=> nest_depth == $past(nest_depth) - 4'h1)
        else $error("depth not lowered");
    depth_bound_a: assert property (nest_depth <= 4'h4) else $error("depth too deep");
endmodule // irq_ctrl_checker

bind irq_ctrl irq_ctrl_checker #(.N(N)) u_irq_ctrl_checker (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .external_request_pin_0(external_request_pin_0),
    .external_request_pin_1(external_request_pin_1), .timer0_req(timer0_req),
    .timer1_req(timer1_req), .timer2_req(timer2_req), .serial_req(serial_req),
    .spi_req(spi_req), .two_wire_req(two_wire_req), .keypad_req(keypad_req),
    .counter_array_req(counter_array_req), .irq_pending(irq_pending),
    .irq_vector(irq_vector), .irq_source(irq_source), .take_ack(take_ack),
    .handler_return(handler_return), .nest_depth(nest_depth));

// File: irq_ctrl_regs.vh
/*
 * Register offsets, field positions, reset values and vector addresses
 * of the four-level interrupt controller.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef IRQ_CTRL_REGS_VH
`define IRQ_CTRL_REGS_VH

// Register indices; the byte address on the bus is four times the index
`define OFS_ENABLE_FIRST     10'h0A8
`define OFS_ENABLE_SECOND    10'h0B1
`define OFS_PRIO_LOW_SECOND  10'h0B2
`define OFS_PRIO_HIGH_SECOND 10'h0B3
`define OFS_PRIO_HIGH_FIRST  10'h0B7
`define OFS_PRIO_LOW_FIRST   10'h0B8
`define OFS_STATUS           10'h0C0
`define OFS_RETURN           10'h0C4

// Source indices, equal to the same-level polling order
`define SRC_EXT0    4'h0
`define SRC_TIMER0  4'h1
`define SRC_EXT1    4'h2
`define SRC_TIMER1  4'h3
`define SRC_SERIAL  4'h4
`define SRC_TIMER2  4'h5
`define SRC_COUNTER 4'h6
`define SRC_KEYPAD  4'h7
`define SRC_SPI     4'h8
`define SRC_TWOWIRE 4'h9
`define NUM_SOURCES 10

// Field positions
`define BIT_GLOBAL_ENABLE 7
`define FIRST_BANK_BITS   7
`define SECOND_BANK_BITS  3

// Reset values
`define RST_ENABLE_FIRST  8'h00
`define RST_FIRST_BANK    7'h00
`define RST_SECOND_BANK   3'h0

// Vector addresses
`define VEC_EXT0    16'h0003
`define VEC_TIMER0  16'h000B
`define VEC_EXT1    16'h0013
`define VEC_TIMER1  16'h001B
`define VEC_SERIAL  16'h0023
`define VEC_TIMER2  16'h002B
`define VEC_COUNTER 16'h0033
`define VEC_KEYPAD  16'h003B
`define VEC_SPI     16'h0043
`define VEC_TWOWIRE 16'h0043

`endif

// File: testbench.sv
/*
 * Self-checking bench for irq_ctrl: registers over APB, enables, vectors,
 * levels, polling order and nesting. Assumes cpu_core_model as the core.
 */
`include "irq_ctrl_regs.vh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0]  pstrb = 4'h1;
    logic [9:0]  req = 10'h000;
    wire         pready, pslverr, irq_pending, take_ack, handler_return;
    wire  [31:0] prdata;
    wire  [15:0] irq_vector;
    wire  [3:0]  irq_source, nest_depth;
    int          failures = 0;
    int          num_checks = 0;
    always #10 clk = ~clk;
    irq_ctrl u_irq_ctrl (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .external_request_pin_0(req[0]),
        .timer0_req(req[1]), .external_request_pin_1(req[2]), .timer1_req(req[3]),
        .serial_req(req[4]), .timer2_req(req[5]), .counter_array_req(req[6]),
        .keypad_req(req[7]), .spi_req(req[8]), .two_wire_req(req[9]),
        .irq_pending(irq_pending), .irq_vector(irq_vector), .irq_source(irq_source),
        .take_ack(take_ack), .handler_return(handler_return), .nest_depth(nest_depth));
    cpu_core_model u_cpu_core_model (.clk(clk), .irq_pending(irq_pending),
        .irq_vector(irq_vector), .irq_source(irq_source), .take_ack(take_ack),
        .handler_return(handler_return));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // Address is a register index; the bus carries four times it
    task automatic apb(input logic wr, input logic [9:0] a, input logic [7:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {a, 2'b00};
        pwdata <= {24'h00_0000, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        logic [31:0] rd;
        logic        e;
        apb(1'b1, a, d, rd, e);
    endtask
    task automatic rdchk(input logic [9:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic        e;
        apb(1'b0, a, 8'h00, rd, e);
        check(rd, exp);
    endtask
    // Expected vector worked out from the slot spacing
    task automatic expect_take(input logic [3:0] src, input logic [3:0] dep);
        logic        got;
        logic [15:0] vec;
        logic [3:0]  s;
        u_cpu_core_model.take(got, vec, s);
        check(got, 1'b1);
        check(s, src);
        check(vec, (src > 4'h7) ? 16'h0043 : {10'h000, src[2:0], 3'h3});
        @(posedge clk);
        check(nest_depth, dep);
    endtask
    task automatic expect_none();
        logic        got;
        logic [15:0] vec;
        logic [3:0]  s;
        u_cpu_core_model.take(got, vec, s);
        check(got, 1'b0);
    endtask
    task automatic t_reset_regs();
        logic [31:0] rd;
        logic        e;
        rdchk(`OFS_ENABLE_FIRST, 32'h0000_0000);
        rdchk(`OFS_PRIO_LOW_FIRST, 32'h0000_0000);
        rdchk(`OFS_PRIO_HIGH_FIRST, 32'h0000_0000);
        rdchk(`OFS_ENABLE_SECOND, 32'h0000_0000);
        rdchk(`OFS_PRIO_LOW_SECOND, 32'h0000_0000);
        rdchk(`OFS_PRIO_HIGH_SECOND, 32'h0000_0000);
        apb(1'b0, 10'h0FC, 8'h00, rd, e);
        check(e, 1'b1);
    endtask
    task automatic t_reg_access();
        wr(`OFS_ENABLE_FIRST, 8'hFF);
        rdchk(`OFS_ENABLE_FIRST, 32'h0000_00FF);
        wr(`OFS_PRIO_LOW_FIRST, 8'hFF);
        rdchk(`OFS_PRIO_LOW_FIRST, 32'h0000_007F);
        wr(`OFS_PRIO_HIGH_FIRST, 8'hFF);
        rdchk(`OFS_PRIO_HIGH_FIRST, 32'h0000_007F);
        pstrb <= 4'h0;
        wr(`OFS_ENABLE_FIRST, 8'h00);
        pstrb <= 4'h1;
        rdchk(`OFS_ENABLE_FIRST, 32'h0000_00FF);
        wr(`OFS_ENABLE_FIRST, 8'h00);
        wr(`OFS_PRIO_LOW_FIRST, 8'h00);
        wr(`OFS_PRIO_HIGH_FIRST, 8'h00);
    endtask
    task automatic t_enables();
        req <= 10'h001;
        wr(`OFS_ENABLE_FIRST, 8'h01);
        expect_none();
        wr(`OFS_ENABLE_FIRST, 8'h80);
        expect_none();
        req <= 10'h000;
    endtask
    // All ten at one level: offers must follow the fixed order
    task automatic t_polling();
        wr(`OFS_ENABLE_FIRST, 8'hFF);
        wr(`OFS_ENABLE_SECOND, 8'h07);
        req <= 10'h3FF;
        for (int i = 0; i < 10; i++) begin
            expect_take(i[3:0], 4'h1);
            req[i] <= 1'b0;
            u_cpu_core_model.ret();
        end
    endtask
    // Timer 1 level 3, ext 0 level 2, serial level 1
    task automatic t_levels();
        wr(`OFS_PRIO_HIGH_FIRST, 8'h09);
        wr(`OFS_PRIO_LOW_FIRST, 8'h18);
        wr(`OFS_ENABLE_FIRST, 8'h99);
        req <= 10'h019;
        expect_take(4'h3, 4'h1);
        expect_none();
        req[3] <= 1'b0;
        u_cpu_core_model.ret();
        expect_take(4'h0, 4'h1);
        expect_none();
        req[0] <= 1'b0;
        u_cpu_core_model.ret();
        expect_take(4'h4, 4'h1);
        req[0] <= 1'b1;
        expect_take(4'h0, 4'h2);
        req <= 10'h000;
        u_cpu_core_model.ret();
        u_cpu_core_model.ret();
        @(negedge clk);
        check(nest_depth, 4'h0);
    endtask
    // Keypad level 2 over SPI level 1; return through the return register
    task automatic t_second_bank();
        wr(`OFS_PRIO_HIGH_SECOND, 8'h01);
        wr(`OFS_PRIO_LOW_SECOND, 8'h04);
        req <= 10'h380;
        expect_take(4'h7, 4'h1);
        req[7] <= 1'b0;
        wr(`OFS_RETURN, 8'h01);
        expect_take(4'h8, 4'h1);
        req <= 10'h000;
        u_cpu_core_model.ret();
    endtask
    task automatic summarize();
        $display("checks %0d, failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        t_reset_regs();
        t_reg_access();
        t_enables();
        t_polling();
        t_levels();
        t_second_bank();
        summarize();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        summarize();
    end
endmodule // testbench
